// ---- design/prescale_tick.sv ----
`timescale 1ns/1ps
`include "wdt_consts.svh"
module prescale_tick #(
  parameter int DIV_WIDTH = `PRESCALE_WIDTH
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic hold_i,
  output logic tick_16_o,
  output logic tick_32_o,
  output logic tick_512_o
);
  initial begin
    if (DIV_WIDTH < $clog2(`DIV_512_RATIO)) $error("prescaler too narrow for divide by 512");
  end

  localparam int W16 = $clog2(`DIV_16_RATIO);
  localparam int W32 = $clog2(`DIV_32_RATIO);
  localparam int W512 = $clog2(`DIV_512_RATIO);

  logic [DIV_WIDTH-1:0] count;
  logic [DIV_WIDTH-1:0] next_count;

  // --------------------------------
  // free-running divider, halted during hold
  // --------------------------------
  always_comb begin
    next_count = hold_i ? count : count + 1'b1;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  // tick on the last count of each power-of-two period
  assign tick_16_o = !hold_i && (&count[W16-1:0]);
  assign tick_32_o = !hold_i && (&count[W32-1:0]);
  assign tick_512_o = !hold_i && (&count[W512-1:0]);
endmodule : prescale_tick

// ---- design/runaway_watchdog_12bit.sv ----
`timescale 1ns/1ps
`include "wdt_consts.svh"
module runaway_watchdog_12bit #(
  parameter int WIDTH = `WDT_WIDTH
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic reset_pin_low_i,
  input wire logic reset_pin_high_voltage_i,
  input wire logic clock_stop_instruction_i,
  input wire logic wdt_write_i,
  input wire logic [15:0] wdt_wdata_i,
  input wire logic freq_sel_write_i,
  input wire logic freq_sel_wdata_i,
  input wire logic soft_reset_write_i,
  input wire logic hold_i,
  input wire logic irq_clear_i,
  input wire wdt_pkg::clock_cfg_t clock_cfg_i,
  output logic [WIDTH-1:0] count_o,
  output logic freq_sel_o,
  output logic irq_request_o,
  output logic soft_reset_pulse_o
);
  initial begin
    if (WIDTH != `WDT_WIDTH) $error("watchdog counter must be twelve bits");
    if (WIDTH <= `WDT_MSB) $error("watchdog counter too narrow for its top bit");
  end

  logic tick_16;
  logic tick_32;
  logic tick_512;
  wdt_pkg::clk_src_t src;
  logic tick;
  logic reload;
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic freq_sel;
  logic next_freq_sel;
  logic irq;
  logic next_irq;
  logic soft_pulse;
  logic next_soft_pulse;
  logic unused_data;
  logic ext_clock;
  logic expired;
  logic count_enable;

  // --------------------------------
  // prescaler
  // --------------------------------
  prescale_tick #(
    .DIV_WIDTH(`PRESCALE_WIDTH)
  ) u_prescale (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .hold_i(hold_i),
    .tick_16_o(tick_16),
    .tick_32_o(tick_32),
    .tick_512_o(tick_512)
  );

  // --------------------------------
  // source selection
  // --------------------------------
  assign ext_clock = (clock_cfg_i.main_ext_input && clock_cfg_i.main_or_div8_system) ||
                     (clock_cfg_i.sub_ext_input && clock_cfg_i.sub_clock_system);

  always_comb begin
    if (ext_clock) begin
      src = wdt_pkg::SRC_DIV_16;
    end else if (freq_sel) begin
      src = wdt_pkg::SRC_DIV_32;
    end else begin
      src = wdt_pkg::SRC_DIV_512;
    end
  end

  // --------------------------------
  // tick multiplexer
  // --------------------------------
  always_comb begin
    case (src)
      wdt_pkg::SRC_DIV_16: tick = tick_16;
      wdt_pkg::SRC_DIV_32: tick = tick_32;
      wdt_pkg::SRC_DIV_512: tick = tick_512;
      default: tick = 1'b0;
    endcase
  end

  assign unused_data = ^wdt_wdata_i;

  // --------------------------------
  // reload causes and count enable
  // --------------------------------
  // top bit low lasts one cycle, the reload below restores it
  assign expired = !count[`WDT_MSB];
  assign reload = reset_pin_low_i || reset_pin_high_voltage_i || clock_stop_instruction_i ||
                  wdt_write_i || expired;
  assign count_enable = tick && !hold_i && !reset_pin_high_voltage_i;

  // --------------------------------
  // counter
  // --------------------------------
  always_comb begin
    next_count = count;
    if (reload) begin
      next_count = `WDT_RELOAD;
    end else if (count_enable) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count <= `WDT_RELOAD;
    end else begin
      count <= next_count;
    end
  end

  // --------------------------------
  // interrupt request
  // --------------------------------
  // expiry in the same cycle as a clear keeps the request set, unless reset_pin_low_i is high
  always_comb begin
    next_irq = irq;
    if (irq_clear_i) begin
      next_irq = 1'b0;
    end
    if (expired && !reset_pin_low_i) begin
      next_irq = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  // --------------------------------
  // frequency selection flag
  // --------------------------------
  always_comb begin
    next_freq_sel = freq_sel;
    if (reset_pin_low_i) begin
      next_freq_sel = 1'b0;
    end else if (freq_sel_write_i) begin
      next_freq_sel = freq_sel_wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      freq_sel <= 1'b0;
    end else begin
      freq_sel <= next_freq_sel;
    end
  end

  // --------------------------------
  // software reset pulse
  // --------------------------------
  always_comb begin
    next_soft_pulse = soft_reset_write_i;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      soft_pulse <= 1'b0;
    end else begin
      soft_pulse <= next_soft_pulse;
    end
  end

  // --------------------------------
  // outputs
  // --------------------------------
  assign count_o = count;
  assign freq_sel_o = freq_sel;
  assign irq_request_o = irq;
  assign soft_reset_pulse_o = soft_pulse;
endmodule : runaway_watchdog_12bit

// ---- design/wdt_consts.svh ----
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH
`define WDT_WIDTH 12
`define WDT_RELOAD 12'hfff
`define WDT_MSB 11
`define DIV_16_RATIO 16
`define DIV_32_RATIO 32
`define DIV_512_RATIO 512
`define PRESCALE_WIDTH 9
`endif

// ---- design/wdt_pkg.sv ----
package wdt_pkg;
  typedef enum logic [1:0] {
    SRC_DIV_512 = 2'b00,
    SRC_DIV_32 = 2'b01,
    SRC_DIV_16 = 2'b10
  } clk_src_t;

  typedef struct packed {
    logic main_ext_input;
    logic main_or_div8_system;
    logic sub_ext_input;
    logic sub_clock_system;
  } clock_cfg_t;
endpackage : wdt_pkg

// ---- verif/runaway_watchdog_12bit_chk.sv ----
`timescale 1ns/1ps
module runaway_watchdog_12bit_chk #(
  parameter int WIDTH = 12
) (
  input wire logic clk_i, nrst_i, reset_pin_low_i, reset_pin_high_voltage_i,
  input wire logic clock_stop_instruction_i, wdt_write_i, soft_reset_write_i,
  input wire logic hold_i, irq_clear_i, freq_sel_o, irq_request_o, soft_reset_pulse_o,
  input wire logic [WIDTH-1:0] count_o
);
  wire kick = wdt_write_i | clock_stop_instruction_i | reset_pin_low_i | reset_pin_high_voltage_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  sequence expired_s; !count_o[WIDTH-1]; endsequence
  reload_a: assert property (kick |=> count_o == 12'hfff) else $error("no reload");
  expire_a: assert property (expired_s |=> count_o == 12'hfff && irq_request_o)
    else $error("no expiry");
  step_a: assert property ($changed(count_o) && count_o != 12'hfff |->
    count_o == $past(count_o) - 12'h001) else $error("bad step");
  hold_a: assert property (hold_i [*2] ##0 (!kick && count_o[WIDTH-1]) |=> $stable(count_o))
    else $error("count moved in hold");
  volt_a: assert property (reset_pin_high_voltage_i [*2] |-> count_o == 12'hfff)
    else $error("counted at high voltage");
  sel_a: assert property (reset_pin_low_i |=> !freq_sel_o) else $error("flag kept");
  pulse_a: assert property (1 |=> soft_reset_pulse_o == $past(soft_reset_write_i))
    else $error("bad reset pulse");
  irq_a: assert property (irq_request_o && !irq_clear_i |=> irq_request_o)
    else $error("request lost");
endmodule : runaway_watchdog_12bit_chk
bind runaway_watchdog_12bit runaway_watchdog_12bit_chk #(.WIDTH(WIDTH)) u_chk (.*);

// ---- verif/test_runaway_watchdog_12bit.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin mismatches++; \
  $display("[ERR] %0t %h %h", $time, a, e); end end
module test_runaway_watchdog_12bit;
  logic clk_i = 0, nrst_i = 0, rl = 0, hv = 0, clock_stop_instruction = 0, wr = 0, fw = 0;
  logic fd = 0, sw = 0, hold = 0, clr = 0, fs, irq, sp;
  logic [15:0] wd = 16'ha5a5;
  logic [11:0] cnt;
  wdt_pkg::clock_cfg_t cfg = '0;
  int mismatches = 0, n_tests = 0, n;
  always #25 clk_i = ~clk_i;
  runaway_watchdog_12bit u_runaway_watchdog_12bit (.clk_i, .nrst_i, .reset_pin_low_i(rl),
    .reset_pin_high_voltage_i(hv), .clock_stop_instruction_i(clock_stop_instruction), .wdt_write_i(wr),
    .wdt_wdata_i(wd), .freq_sel_write_i(fw), .freq_sel_wdata_i(fd), .soft_reset_write_i(sw),
    .hold_i(hold), .irq_clear_i(clr), .clock_cfg_i(cfg), .count_o(cnt), .freq_sel_o(fs),
    .irq_request_o(irq), .soft_reset_pulse_o(sp));
  task cyc(int k); repeat (k) @(posedge clk_i); #1; endtask : cyc
  task sel(logic v); fd = v; fw = 1; cyc(1); fw = 0; endtask : sel
  task t_boot;
    cyc(400);
    `CHK(cnt, 12'hfff)
    `CHK(fs, 1'b0)
    cyc(200);
    `CHK(cnt, 12'hffe)
  endtask : t_boot
  task t_reload;
    sel(1);
    for (int i = 0; i < 4; i++) begin
      cyc(100);
      {rl, hv, clock_stop_instruction, wr} = 4'h1 << i;
      cyc(1);
      {rl, hv, clock_stop_instruction, wr} = 4'h0;
      `CHK(cnt, 12'hfff)
    end
    `CHK(fs, 1'b0)
  endtask : t_reload
  task t_hold;
    sel(1);
    cyc(100);
    hold = 1;
    cyc(2);
    n = cnt;
    cyc(200);
    `CHK(cnt, n[11:0])
    hold = 0;
    hv = 1;
    cyc(200);
    `CHK(cnt, 12'hfff)
    hv = 0;
  endtask : t_hold
  task t_soft;
    sw = 1;
    cyc(1);
    sw = 0;
    `CHK(sp, 1'b1)
    cyc(1);
    `CHK(sp, 1'b0)
  endtask : t_soft
  task t_ext(wdt_pkg::clock_cfg_t c);
    sel(0);
    cfg = c;
    wr = 1;
    cyc(1);
    wr = 0;
    cyc(100);
    `CHK(cnt <= 12'hffa, 1'b1)
    cfg = '0;
  endtask : t_ext
  task t_expire;
    sel(1);
    wr = 1;
    cyc(1);
    wr = 0;
    n = 0;
    while (irq !== 1'b1 && n < 70000) begin cyc(1); n++; end
    `CHK(n > 65400 && n < 65600, 1'b1)
    `CHK(cnt, 12'hfff)
    clr = 1;
    cyc(1);
    clr = 0;
    `CHK(irq, 1'b0)
  endtask : t_expire
  task print_verdict;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    cyc(12);
    nrst_i = 1;
    t_boot; t_reload; t_hold; t_soft; t_ext(4'hc); t_ext(4'h3); t_expire;
    print_verdict;
  end
  initial begin #5000000; mismatches++; print_verdict; end
endmodule : test_runaway_watchdog_12bit
